// >>> design/dep_pkg.sv
// Package of constants for the debug event pin block
package dep_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_CONTROL    = 4'h0;
   localparam logic [3:0] OFS_STATUS     = 4'h4;
   localparam logic [3:0] OFS_IRQ_MASK   = 4'h8;
   localparam logic [3:0] OFS_BP_CONTROL = 4'hC;
   // ------------------------------------------------------------
   // Field layout of the debug control register
   // ------------------------------------------------------------
   localparam int EIC_LSB = 0;
   localparam int EOS_LSB = 2;
   // ------------------------------------------------------------
   // Status bits (also the mask layout)
   // ------------------------------------------------------------
   localparam int ST_EXT_BREAK  = 0;
   localparam int ST_DEBUG_ENTR = 1;
   localparam int ST_BP_HIT     = 2;
   localparam int ST_WIDTH      = 3;
   // ------------------------------------------------------------
   // Encodings and reset values
   // ------------------------------------------------------------
   localparam int NUM_BP = 4;
   localparam logic [1:0] EIC_BREAK      = 2'h1;
   localparam logic [1:0] EOS_DEBUG_ENTR = 2'h1;
   localparam logic [1:0] EOS_BP_STATUS  = 2'h2;
   localparam logic [1:0] RST_FIELD      = 2'h0;
   localparam logic [31:0] RST_WORD      = 32'h0000_0000;
   typedef enum logic [1:0] {
      DEP_IDLE = 2'b00,
      DEP_RESP = 2'b01
   } dep_bus_type;
endpackage

// >>> design/dep_event_pins.sv
// Debug event-in and event-out pin logic with Avalon-MM register slave
// What this block does
// - With event_in_control at 01 a high-to-low edge on event_in_pin raises a break request.
// - A break caused by event_in_pin sets external_break_flag in debug_status.
// - With event_out_select at 01 event_out_pin goes low one clock per debug-mode entry.
// - A breakpoint or watchpoint whose event-out enable is set shows its hit on event_out_pin.
// - Hit status reaches event_out_pin only while event_out_select holds 10.
//
// Register map, all words 32 bits wide, narrow fields in the low bits:
//   control   : event_in_control in bits 1:0, event_out_select in bits 3:2
//   status    : sticky event bits, cleared by a read of the register
//   irq mask  : same layout as status, one enables the interrupt
//   bp enable : one event-out enable bit per breakpoint or watchpoint unit
// Unmapped offsets ignore writes and read back as zero.
//
// Bus timing: every request costs exactly one wait cycle. Read data is
// latched in the wait cycle, so it already stands at the taking edge.
// The status clear removes only the bits that the read returned, so an
// event that lands after the latch is never lost.
//
// Pins: event_in_pin idles high, its falling edge is the event;
// event_out_pin idles high and is driven low to signal.
`timescale 1ns/100ps
`default_nettype none
module dep_event_pins (
   input  wire logic                       clk_sys,
   input  wire logic                       srst,
   input  wire logic [3:0]                 avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   output logic      [31:0]                avs_readdata,
   output logic                            avs_waitrequest,
   output logic                            irq,
   input  wire logic                       event_in_pin,
   output logic                            event_out_pin,
   input  wire logic                       debug_mode,
   input  wire logic [dep_pkg::NUM_BP-1:0] bp_hit,
   output logic                            break_request
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   dep_pkg::dep_bus_type             bus_state;
   logic [1:0]                       event_in_control;
   logic [1:0]                       event_out_select;
   logic [dep_pkg::ST_WIDTH-1:0]     debug_status;
   logic [dep_pkg::ST_WIDTH-1:0]     irq_mask;
   logic [dep_pkg::NUM_BP-1:0]       bp_out_enable;
   logic                             evi_prev;
   logic                             dbg_prev;
   logic                             evi_fall;
   logic                             dbg_entry;
   logic                             bp_any;
   logic                             wr_take;
   logic                             rd_take;
   logic [dep_pkg::ST_WIDTH-1:0]     ev_set;

   function automatic logic hit_ofs(input logic [3:0] a, input logic [3:0] o);
      hit_ofs = (a == o);
   endfunction

   // ------------------------------------------------------------
   // Bus handshake: one wait cycle, answer on the second edge
   // ------------------------------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & (bus_state == dep_pkg::DEP_IDLE);
   assign wr_take = avs_write & ~avs_waitrequest;
   assign rd_take = avs_read & ~avs_waitrequest;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bus_state <= dep_pkg::DEP_IDLE;
      end else begin
         case (bus_state)
            dep_pkg::DEP_IDLE: begin
               if (avs_read | avs_write) begin
                  bus_state <= dep_pkg::DEP_RESP;
               end
            end
            dep_pkg::DEP_RESP: bus_state <= dep_pkg::DEP_IDLE;
            default:           bus_state <= dep_pkg::DEP_IDLE;
         endcase
      end
   end

   // Read data latched while waitrequest is high so it stands at the taking edge
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         avs_readdata <= dep_pkg::RST_WORD;
      end else if (avs_read & avs_waitrequest) begin
         avs_readdata <= dep_pkg::RST_WORD;
         if (hit_ofs(avs_address, dep_pkg::OFS_CONTROL)) begin
            avs_readdata[dep_pkg::EIC_LSB +: 2] <= event_in_control;
            avs_readdata[dep_pkg::EOS_LSB +: 2] <= event_out_select;
         end else if (hit_ofs(avs_address, dep_pkg::OFS_STATUS)) begin
            avs_readdata[dep_pkg::ST_WIDTH-1:0] <= debug_status;
         end else if (hit_ofs(avs_address, dep_pkg::OFS_IRQ_MASK)) begin
            avs_readdata[dep_pkg::ST_WIDTH-1:0] <= irq_mask;
         end else if (hit_ofs(avs_address, dep_pkg::OFS_BP_CONTROL)) begin
            avs_readdata[dep_pkg::NUM_BP-1:0] <= bp_out_enable;
         end
      end
   end

   // ------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         event_in_control <= dep_pkg::RST_FIELD;
         event_out_select <= dep_pkg::RST_FIELD;
         irq_mask         <= '0;
         bp_out_enable    <= '0;
      end else if (wr_take) begin
         if (hit_ofs(avs_address, dep_pkg::OFS_CONTROL)) begin
            event_in_control <= avs_writedata[dep_pkg::EIC_LSB +: 2];
            event_out_select <= avs_writedata[dep_pkg::EOS_LSB +: 2];
         end
         if (hit_ofs(avs_address, dep_pkg::OFS_IRQ_MASK)) begin
            irq_mask <= avs_writedata[dep_pkg::ST_WIDTH-1:0];
         end
         if (hit_ofs(avs_address, dep_pkg::OFS_BP_CONTROL)) begin
            bp_out_enable <= avs_writedata[dep_pkg::NUM_BP-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Edge detection on pin and debug-mode level
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         evi_prev <= 1'b1;
         dbg_prev <= 1'b0;
      end else begin
         evi_prev <= event_in_pin;
         dbg_prev <= debug_mode;
      end
   end

   // A low lasting one clock is seen, as the driver guarantees
   assign evi_fall  = evi_prev & ~event_in_pin;
   assign dbg_entry = debug_mode & ~dbg_prev;
   assign bp_any    = |(bp_hit & bp_out_enable);

   // Break request one clock after a qualified falling edge
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         break_request <= 1'b0;
      end else begin
         break_request <= evi_fall & (event_in_control == dep_pkg::EIC_BREAK);
      end
   end

   // ------------------------------------------------------------
   // Sticky status; a new event wins over the clear-on-read
   // ------------------------------------------------------------
   always_comb begin
      ev_set = '0;
      ev_set[dep_pkg::ST_EXT_BREAK]  = evi_fall & (event_in_control == dep_pkg::EIC_BREAK);
      ev_set[dep_pkg::ST_DEBUG_ENTR] = dbg_entry;
      ev_set[dep_pkg::ST_BP_HIT]     = bp_any;
   end

   // Clear only the returned bits; an event after the latch must survive
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         debug_status <= '0;
      end else if (rd_take & hit_ofs(avs_address, dep_pkg::OFS_STATUS)) begin
         debug_status <= (debug_status & ~avs_readdata[dep_pkg::ST_WIDTH-1:0]) | ev_set;
      end else begin
         debug_status <= debug_status | ev_set;
      end
   end

   // Level interrupt straight from registers, no extra latency
   assign irq = |(debug_status & irq_mask);

   // ------------------------------------------------------------
   // Event-out pin, active low, registered
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         event_out_pin <= 1'b1;
      end else begin
         case (event_out_select)
            dep_pkg::EOS_DEBUG_ENTR: event_out_pin <= ~dbg_entry;
            dep_pkg::EOS_BP_STATUS:  event_out_pin <= ~bp_any;
            default:                 event_out_pin <= 1'b1;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   ext_break_a: assert property (@(posedge clk_sys) disable iff (srst)
      (evi_fall && event_in_control == dep_pkg::EIC_BREAK) |=> break_request)
      else $error("falling edge did not raise break request");
   no_break_a: assert property (@(posedge clk_sys) disable iff (srst)
      break_request |-> $past(event_in_control) == dep_pkg::EIC_BREAK && $fell(evi_prev))
      else $error("break request without qualified edge");
   flag_set_a: assert property (@(posedge clk_sys) disable iff (srst)
      break_request |-> debug_status[dep_pkg::ST_EXT_BREAK])
      else $error("external break flag not set");
   entry_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
      ($rose(debug_mode) && event_out_select == dep_pkg::EOS_DEBUG_ENTR)
      |=> !event_out_pin ##1 (event_out_pin || $rose(debug_mode)))
      else $error("debug entry pulse wrong");
   bp_show_a: assert property (@(posedge clk_sys) disable iff (srst)
      (event_out_select == dep_pkg::EOS_BP_STATUS && |(bp_hit & bp_out_enable))
      |=> !event_out_pin)
      else $error("breakpoint hit not shown");
   bp_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
      (event_out_select == dep_pkg::EOS_BP_STATUS && !(|(bp_hit & bp_out_enable)))
      |=> event_out_pin)
      else $error("event out low without hit");
   idle_high_a: assert property (@(posedge clk_sys) disable iff (srst)
      (event_out_select != dep_pkg::EOS_DEBUG_ENTR && event_out_select != dep_pkg::EOS_BP_STATUS)
      |=> event_out_pin)
      else $error("event out not idle high");
   wait_one_a: assert property (@(posedge clk_sys) disable iff (srst)
      ($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   // Guards skip cycles where a read, any write or reset changed the inputs
   irq_lvl_a: assert property (@(posedge clk_sys) disable iff (srst)
      ($past(debug_status & irq_mask) != '0 && !$past(rd_take) && !$past(wr_take)
       && !$past(srst)) |-> irq)
      else $error("interrupt missing");
   irq_low_a: assert property (@(posedge clk_sys) disable iff (srst)
      ((debug_status & irq_mask) == '0) |-> !irq)
      else $error("interrupt without unmasked status");
   // A falling edge needs the pin high again, so requests never touch
   break_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
      break_request |=> !break_request)
      else $error("break request longer than one cycle");
   // Sticky flag holds until the status register is read
   flag_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
      (debug_status[dep_pkg::ST_EXT_BREAK]
       && !(rd_take && hit_ofs(avs_address, dep_pkg::OFS_STATUS)))
      |=> debug_status[dep_pkg::ST_EXT_BREAK])
      else $error("external break flag lost");
   // An event in the clearing cycle must not be swallowed
   set_wins_a: assert property (@(posedge clk_sys) disable iff (srst)
      (ev_set != '0) |=> ((debug_status & $past(ev_set)) == $past(ev_set)))
      else $error("status event lost");
   // In entry mode the pin is low only right after an entry
   entry_only_a: assert property (@(posedge clk_sys) disable iff (srst)
      (event_out_select == dep_pkg::EOS_DEBUG_ENTR && !dbg_entry) |=> event_out_pin)
      else $error("event out low without debug entry");
   // Unmapped reads return zero
   ro_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
      (avs_read && avs_waitrequest && !hit_ofs(avs_address, dep_pkg::OFS_CONTROL)
       && !hit_ofs(avs_address, dep_pkg::OFS_STATUS)
       && !hit_ofs(avs_address, dep_pkg::OFS_IRQ_MASK)
       && !hit_ofs(avs_address, dep_pkg::OFS_BP_CONTROL))
      |=> avs_readdata == dep_pkg::RST_WORD)
      else $error("unmapped read not zero");

   break_c: cover property (@(posedge clk_sys) disable iff (srst) break_request);
   entry_c: cover property (@(posedge clk_sys) disable iff (srst)
      event_out_select == dep_pkg::EOS_DEBUG_ENTR && !event_out_pin);
   bp_c:    cover property (@(posedge clk_sys) disable iff (srst)
      event_out_select == dep_pkg::EOS_BP_STATUS && !event_out_pin);
   irq_c:   cover property (@(posedge clk_sys) disable iff (srst) irq ##1 !irq);
   clear_c: cover property (@(posedge clk_sys) disable iff (srst)
      rd_take && hit_ofs(avs_address, dep_pkg::OFS_STATUS) && debug_status != '0);
endmodule
`default_nettype wire

// >>> tb/dep_trig_model.sv
// Outside trigger source and scope model for the debug event pins
`timescale 1ns/100ps
`default_nettype none
module dep_trig_model (
   input  wire logic       clk_sys,
   input  wire logic       fire,
   input  wire logic [2:0] hold_cycles,
   input  wire logic       event_out_pin,
   output logic            event_in_pin,
   output logic [7:0]      low_count
);
   logic [2:0] left = 3'h0;
   // Source idles high; a shot pulls the line low for whole cycles only
   always @(posedge clk_sys) begin
      if (fire && left == 3'h0) begin
         left <= (hold_cycles == 3'h0) ? 3'h1 : hold_cycles;
      end else if (left != 3'h0) begin
         left <= left - 3'h1;
      end
   end
   assign event_in_pin = (left == 3'h0);
   // Scope counts low cycles, so a stretched or lost pulse shows up
   initial low_count = 8'h00;
   always @(posedge clk_sys) begin
      if (event_out_pin == 1'b0) begin
         low_count <= low_count + 8'h01;
      end
   end
endmodule
`default_nettype wire

// >>> tb/test_dep_event_pins.sv
// Self-checking bench for the debug event pin block
`timescale 1ns/100ps
`default_nettype none
module test_dep_event_pins;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic        debug_mode = 1'b0;
   logic        fire = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic [3:0]  bp_hit = 4'h0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata, rd;
   logic [2:0]  hold_cycles = 3'h1;
   logic [7:0]  low_count, c0;
   logic        avs_waitrequest, irq, event_in_pin, event_out_pin, break_request;
   int          fail_count = 0;
   int          n_compared = 0;
   int          brk_count = 0;
   // Clock, block and far-side model
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   dep_event_pins dut (.clk_sys, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .irq, .event_in_pin, .event_out_pin, .debug_mode,
      .bp_hit, .break_request);
   dep_trig_model scope (.clk_sys, .fire, .hold_cycles, .event_out_pin, .event_in_pin,
      .low_count);
   // Cycles with break_request high are counted, so a stretched pulse is caught too
   always @(posedge clk_sys) begin
      if (break_request === 1'b1) brk_count++;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus cycle; holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      check("waitrequest", {31'h0, avs_waitrequest}, 32'h0000_0000);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0000_0000);
      check(what, rd, exp);
   endtask
   task automatic fire_pin(input logic [2:0] hold);
      brk_count = 0;
      hold_cycles <= hold;
      fire <= 1'b1;
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic t_reset;
      rd_chk(dep_pkg::OFS_CONTROL, dep_pkg::RST_WORD, "control");
      rd_chk(dep_pkg::OFS_IRQ_MASK, dep_pkg::RST_WORD, "mask");
      rd_chk(dep_pkg::OFS_BP_CONTROL, dep_pkg::RST_WORD, "bp enable");
      bus(1'b1, 4'h1, 32'hFFFF_FFFF);
      rd_chk(4'h1, 32'h0000_0000, "unmapped");
      rd_chk(dep_pkg::OFS_CONTROL, dep_pkg::RST_WORD, "control kept");
      check("idle pin", {31'h0, event_out_pin}, 32'h0000_0001);
   endtask
   task automatic t_event_in;
      fire_pin(3'h1);
      check("break off", brk_count, 0);
      rd_chk(dep_pkg::OFS_STATUS, 32'h0000_0000, "status off");
      bus(1'b1, dep_pkg::OFS_CONTROL, 32'(dep_pkg::EIC_BREAK));
      bus(1'b1, dep_pkg::OFS_IRQ_MASK, 32'h1 << dep_pkg::ST_EXT_BREAK);
      fire_pin(3'h1);
      check("break on", brk_count, 1);
      check("irq set", {31'h0, irq}, 32'h0000_0001);
      rd_chk(dep_pkg::OFS_STATUS, 32'h1 << dep_pkg::ST_EXT_BREAK, "flag");
      @(posedge clk_sys);
      check("irq clear", {31'h0, irq}, 32'h0000_0000);
      rd_chk(dep_pkg::OFS_STATUS, 32'h0000_0000, "flag clear");
      fire_pin(3'h4);
      check("long low", brk_count, 1);
   endtask
   task automatic t_entry;
      bus(1'b1, dep_pkg::OFS_CONTROL, 32'(dep_pkg::EOS_DEBUG_ENTR) << dep_pkg::EOS_LSB);
      c0 = low_count;
      repeat (2) begin
         debug_mode <= 1'b1;
         repeat (4) @(posedge clk_sys);
         debug_mode <= 1'b0;
         repeat (2) @(posedge clk_sys);
      end
      check("entry pulses", 32'(low_count - c0), 32'h0000_0002);
   endtask
   task automatic t_bp;
      bus(1'b1, dep_pkg::OFS_BP_CONTROL, 32'h0000_0002);
      bus(1'b1, dep_pkg::OFS_CONTROL, 32'(dep_pkg::EOS_BP_STATUS) << dep_pkg::EOS_LSB);
      c0 = low_count;
      bp_hit <= 4'h1;
      repeat (6) @(posedge clk_sys);
      check("masked hit", 32'(low_count - c0), 32'h0000_0000);
      bp_hit <= 4'h2;
      repeat (5) @(posedge clk_sys);
      bp_hit <= 4'h0;
      repeat (3) @(posedge clk_sys);
      check("hit cycles", 32'(low_count - c0), 32'h0000_0005);
   endtask
   // Select values under which hits may not reach the pin, nor entry where the test drives one
   task automatic t_quiet(input logic [1:0] sel, input logic entry);
      bus(1'b1, dep_pkg::OFS_CONTROL, 32'(sel) << dep_pkg::EOS_LSB);
      c0 = low_count;
      debug_mode <= entry;
      bp_hit <= 4'hF;
      repeat (6) @(posedge clk_sys);
      debug_mode <= 1'b0;
      bp_hit <= 4'h0;
      repeat (3) @(posedge clk_sys);
      check("quiet pin", 32'(low_count - c0), 32'h0000_0000);
   endtask
   // Reset in mid-run returns registers, status and pin to idle
   task automatic t_rerun;
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      check("pin after reset", {31'h0, event_out_pin}, 32'h0000_0001);
      rd_chk(dep_pkg::OFS_CONTROL, dep_pkg::RST_WORD, "control after reset");
      rd_chk(dep_pkg::OFS_STATUS, dep_pkg::RST_WORD, "status after reset");
   endtask
   task automatic conclude;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      t_reset;
      t_event_in;
      t_entry;
      t_bp;
      t_quiet(dep_pkg::EOS_DEBUG_ENTR, 1'b0);
      t_quiet(dep_pkg::RST_FIELD, 1'b1);
      t_quiet(2'h3, 1'b1);
      t_rerun;
      conclude;
   end
   // Watchdog well beyond the roughly 150 cycles the tests need
   initial begin
      #20000;
      fail_count++;
      conclude;
   end
endmodule
`default_nettype wire
